// File: rtl/tec_timer_ctrl.sv
// Purpose: Timer/event counter channel: control registers, clock select, compare one
// Assumes: APB slave with zero wait states, pins asynchronous to pclk
// Notes: Compare buffer one is hidden behind capture/compare register one
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module tec_timer_ctrl
#(
  parameter bit HAS_SUBCLOCK = 1'b0,
  parameter bit IS_MASTER = 1'b1
)
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins
  input wire logic timer_input_a,
  input wire logic timer_input_b,
  output logic timer_output_a,
  output logic timer_output_b,
  // Clock sources
  input wire logic sub_clock_freq,
  input wire logic main_clock_stopped,
  // Channel synchronisation
  input wire logic sync_tick_in,
  output logic sync_tick_out,
  // Events
  output logic match_one_irq,
  output logic trigger_start
);
  import tec_pkg::*;

  initial
  begin
    if (PRESC_W != 7)
    begin
      $error("tec_timer_ctrl: prescaler must be 7 bits");
    end
  end

  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [3:0] outctl;
    logic [3:0] capedge;
    logic [3:0] evtedge;
    logic [1:0] ccs;
    logic ovf;
    logic [15:0] capcmp;
    logic [15:0] cbuf;
    logic [15:0] count;
    logic [6:0] presc;
    tec_run_t run;
    logic tog_a;
    logic tog_b;
    logic irq;
    logic trig;
    logic [31:0] rdata;
  } tec_state_t;

  tec_state_t st_reg;
  tec_state_t st_next;

  logic ev_a;
  logic trig_a;
  logic cap_b;
  logic sub_edge;

  tec_edge u_event_a
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(timer_input_a),
    .edge_sel(st_reg.evtedge[3:2]),
    .valid_edge(ev_a)
  );

  tec_edge u_trigger_a
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(timer_input_a),
    .edge_sel(st_reg.evtedge[1:0]),
    .valid_edge(trig_a)
  );

  tec_edge u_capture_b
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(timer_input_b),
    .edge_sel(st_reg.capedge[3:2]),
    .valid_edge(cap_b)
  );

  tec_edge u_subclock
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(sub_clock_freq),
    .edge_sel(EDGE_RISE_ONLY),
    .valid_edge(sub_edge)
  );

  logic enabled;
  logic [2:0] cks;
  tec_mode_t mode;
  logic [6:0] presc_mask;
  logic int_tick;
  logic own_tick;
  logic tick;
  logic use_event;
  logic capture_mode;
  logic trig_mode;
  logic sw_trig;
  logic wr;
  logic rd_setup;
  logic access;
  logic hit;
  logic [29:0] idx;
  logic [15:0] cnt_inc;
  logic wrap;

  assign idx = paddr[31:2];
  assign enabled = st_reg.ctl0[BIT_RUN];
  assign cks = st_reg.ctl0[2:0];
  assign mode = tec_mode_t'(st_reg.ctl1[2:0]); // (R19)
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb
  begin
    case (idx)
      IDX_CTL0, IDX_CTL1, IDX_OUTCTL, IDX_CAPEDGE, IDX_EVTEDGE, IDX_OPTION, IDX_CAPCMP1,
      IDX_COUNT:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
  end

  // Internal divider: code k ticks once every 2**k cycles
  assign presc_mask = PRESC_ALL >> (CKS_TOP - cks); // (R9)
  always_comb
  begin
    if (HAS_SUBCLOCK && cks == CKS_TOP)
    begin
      int_tick = sub_edge & ~main_clock_stopped; // (R9) (R10)
    end
    else
    begin
      int_tick = (st_reg.presc & presc_mask) == presc_mask; // (R9)
    end
  end

  assign use_event = st_reg.ctl1[BIT_EVT] | (mode == MD_EVENT); // (R18) (R20)
  assign own_tick = use_event ? ev_a : int_tick; // (R6) (R18)
  assign tick = (!IS_MASTER && st_reg.ctl1[BIT_SYNC]) ? sync_tick_in : own_tick; // (R13)
  assign sync_tick_out = enabled & own_tick;

  assign capture_mode = st_reg.ccs[1] & ((mode == MD_FREE) | (mode == MD_WIDTH));
  assign trig_mode = (mode == MD_EXTTRIG) | (mode == MD_ONESHOT);
  // Software trigger only in the two pulse modes
  assign sw_trig = wr & pstrb[0] & (idx == IDX_CTL1) & pwdata[BIT_SWTRIG] &
                   ((pwdata[2:0] == MD_EXTTRIG) | (pwdata[2:0] == MD_ONESHOT)); // (R15) (R16)

  assign cnt_inc = st_reg.count + 16'h0001;
  assign wrap = st_reg.count == CNT_IDLE;

  always_comb
  begin
    st_next = st_reg;
    st_next.irq = 1'b0;
    st_next.trig = 1'b0;
    st_next.presc = st_reg.presc + 7'h01;

    // Register writes
    if (wr)
    begin
      case (idx)
        IDX_CTL0:
        begin
          if (pstrb[0])
          begin
            st_next.ctl0 = pwdata[7:0] & CTL0_MASK; // (R7)
          end
        end
        IDX_CTL1:
        begin
          if (pstrb[0])
          begin
            st_next.ctl1 = pwdata[7:0] & CTL1_MASK & ~(8'h01 << BIT_SWTRIG);
          end
        end
        IDX_OUTCTL:
        begin
          if (pstrb[0])
          begin
            st_next.outctl = pwdata[3:0];
          end
        end
        IDX_CAPEDGE:
        begin
          if (pstrb[0])
          begin
            st_next.capedge = pwdata[3:0];
          end
        end
        IDX_EVTEDGE:
        begin
          if (pstrb[0])
          begin
            st_next.evtedge = pwdata[3:0];
          end
        end
        IDX_OPTION:
        begin
          if (pstrb[0])
          begin
            st_next.ccs = pwdata[5:4];
            st_next.ovf = st_reg.ovf & pwdata[BIT_OVF];
          end
        end
        IDX_CAPCMP1:
        begin
          if (!capture_mode)
          begin
            if (pstrb[0])
            begin
              st_next.capcmp[7:0] = pwdata[7:0];
              st_next.cbuf[7:0] = pwdata[7:0]; // (R1) (R3)
            end
            if (pstrb[1])
            begin
              st_next.capcmp[15:8] = pwdata[15:8];
              st_next.cbuf[15:8] = pwdata[15:8]; // (R1) (R3)
            end
          end
        end
        default:
        begin
        end
      endcase
    end

    // Counter and run state
    case (st_reg.run)
      RUN_OFF:
      begin
        st_next.count = CNT_IDLE; // (R22)
        if (enabled)
        begin
          st_next.run = trig_mode ? RUN_WAIT : RUN_GO; // (R8)
          st_next.count = trig_mode ? CNT_IDLE : CNT_START;
        end
      end
      RUN_WAIT:
      begin
        if (sw_trig || trig_a)
        begin
          st_next.run = RUN_GO; // (R15)
          st_next.count = CNT_START;
          st_next.trig = 1'b1;
        end
      end
      RUN_GO:
      begin
        if (trig_mode && (sw_trig || trig_a))
        begin
          st_next.count = CNT_START; // (R15)
          st_next.trig = 1'b1;
        end
        else if (tick)
        begin
          st_next.count = cnt_inc; // (R6)
          if (wrap)
          begin
            st_next.tog_a = ~st_reg.tog_a;
            if (mode == MD_ONESHOT)
            begin
              st_next.run = RUN_WAIT;
              st_next.count = CNT_IDLE;
            end
          end
          if (!capture_mode && cnt_inc == st_reg.cbuf)
          begin
            st_next.irq = 1'b1; // (R2) (R24)
            st_next.tog_b = ~st_reg.tog_b;
          end
        end
      end
      default:
      begin
        st_next.run = RUN_OFF;
      end
    endcase

    // Overflow: set wins over a software clear
    if (st_reg.run == RUN_GO && tick && wrap && !(trig_mode && (sw_trig || trig_a)))
    begin
      st_next.ovf = 1'b1;
    end

    // Capture on timer input b edge
    if (capture_mode && enabled && cap_b)
    begin
      st_next.capcmp = st_reg.count; // (R5)
    end

    // Disabled: stop and reset overflow, counter and outputs
    if (!enabled)
    begin
      st_next.run = RUN_OFF; // (R8)
      st_next.count = CNT_IDLE; // (R8) (R22)
      st_next.ovf = 1'b0; // (R8)
      st_next.tog_a = 1'b0; // (R8)
      st_next.tog_b = 1'b0; // (R8)
      st_next.irq = 1'b0;
      st_next.trig = 1'b0;
    end

    // Read data captured in the setup phase
    if (rd_setup)
    begin
      case (idx)
        IDX_CTL0:
          st_next.rdata = {24'h000000, st_reg.ctl0};
        IDX_CTL1:
          st_next.rdata = {24'h000000, st_reg.ctl1};
        IDX_OUTCTL:
          st_next.rdata = {28'h0000000, st_reg.outctl};
        IDX_CAPEDGE:
          st_next.rdata = {28'h0000000, st_reg.capedge};
        IDX_EVTEDGE:
          st_next.rdata = {28'h0000000, st_reg.evtedge};
        IDX_OPTION:
          st_next.rdata = {26'h0000000, st_reg.ccs, 3'h0, st_reg.ovf};
        IDX_CAPCMP1:
          st_next.rdata = {16'h0000, st_reg.capcmp};
        IDX_COUNT:
          st_next.rdata = {16'h0000, enabled ? st_reg.count : CNT_READ_OFF}; // (R22)
        default:
          st_next.rdata = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg.ctl0 <= CTL0_RST;
      st_reg.ctl1 <= CTL1_RST;
      st_reg.outctl <= NIB_RST;
      st_reg.capedge <= NIB_RST;
      st_reg.evtedge <= NIB_RST;
      st_reg.ccs <= 2'h0;
      st_reg.ovf <= 1'b0;
      st_reg.capcmp <= CCR_RST; // (R4)
      st_reg.cbuf <= CCR_RST; // (R4)
      st_reg.count <= CNT_IDLE;
      st_reg.presc <= 7'h00;
      st_reg.run <= RUN_OFF;
      st_reg.tog_a <= 1'b0;
      st_reg.tog_b <= 1'b0;
      st_reg.irq <= 1'b0;
      st_reg.trig <= 1'b0;
      st_reg.rdata <= RD_ZERO;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Output controller: level bit inverts even while stopped
  assign timer_output_a = (st_reg.outctl[BIT_OE0] & st_reg.tog_a) ^ st_reg.outctl[BIT_OL0];
  assign timer_output_b = (st_reg.outctl[BIT_OE1] & st_reg.tog_b) ^ st_reg.outctl[BIT_OL1];

  assign match_one_irq = st_reg.irq; // (R24)
  assign trigger_start = st_reg.trig;
  assign prdata = st_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
endmodule : tec_timer_ctrl
`default_nettype wire

// File: rtl/tec_pkg.sv
// Purpose: Constants and types for one timer/event counter channel control side
// Assumes: APB slave, 8-bit and 16-bit registers in the low lanes of 32-bit words
// Notes: Byte address of a register is four times its index
//
// Behaviour
// (R1) Software writes to compare register one are copied into the hidden compare buffer.
// (R2) Count equal to compare buffer raises the channel-one match request.
// (R3) Compare buffer has no address; only the compare register loads it.
// (R4) Reset clears compare register one and its buffer to zero.
// (R5) Edge detector watches both inputs; none, rising, falling or both edges valid.
// (R6) Counter clock comes from eight internal choices or external event edges.
// (R7) Control register 0 accepts any write in any state.
// (R8) Enable low stops and resets overflow, counter, outputs; enable high starts counting.
// (R9) Clock select picks main clock divided by 1 to 128; code 7 subclock option.
// (R10) Subclock selected with main clock stopped gives no counting.
// (R11) Software changes clock select only while disabled or when enabling.
// (R12) Software writes zeros to control register 0 bits 3 to 6.
// (R13) Sync bit low runs independently; high follows the master channel count clock.
// (R14) Software keeps the sync bit cleared on master channels.
// (R15) Software trigger write acts as external trigger in pulse and one-shot modes.
// (R16) Software trigger is ignored in all other modes.
// (R17) Software writes zeros to control register 1 bits 3 and 4.
// (R18) External-event enable chooses internal clock or external event edges.
// (R19) Mode field codes 0 to 6 select the seven timer modes; 7 prohibited.
// (R20) External event count mode counts event edges whatever the enable bit.
// (R21) Software changes event enable and mode only while disabled.
// (R22) Disabled counter holds all ones; a read of the count returns zero.
// (R23) Edge codes: 00 none, 01 rising, 10 falling, 11 both.
// (R24) Match request is a one-cycle pulse in the cycle of detection.
package tec_pkg;
  localparam logic [29:0] IDX_CTL0 = 30'h0ffff590;
  localparam logic [29:0] IDX_CTL1 = 30'h0ffff591;
  localparam logic [29:0] IDX_OUTCTL = 30'h0ffff592;
  localparam logic [29:0] IDX_CAPEDGE = 30'h0ffff593;
  localparam logic [29:0] IDX_EVTEDGE = 30'h0ffff594;
  localparam logic [29:0] IDX_OPTION = 30'h0ffff595;
  localparam logic [29:0] IDX_CAPCMP1 = 30'h0ffff597;
  localparam logic [29:0] IDX_COUNT = 30'h0ffff598;

  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL0_MASK = 8'h87;
  localparam logic [7:0] CTL1_MASK = 8'ha7;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [15:0] CCR_RST = 16'h0000;
  localparam logic [15:0] CNT_IDLE = 16'hffff;
  localparam logic [15:0] CNT_START = 16'h0000;
  localparam logic [15:0] CNT_READ_OFF = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h00000000;

  localparam int BIT_RUN = 7;
  localparam int BIT_SYNC = 7;
  localparam int BIT_SWTRIG = 6;
  localparam int BIT_EVT = 5;
  localparam int BIT_OVF = 0;
  localparam int BIT_CCS1 = 5;
  localparam int BIT_OE0 = 0;
  localparam int BIT_OL0 = 1;
  localparam int BIT_OE1 = 2;
  localparam int BIT_OL1 = 3;

  localparam int PRESC_W = 7;
  localparam logic [6:0] PRESC_ALL = 7'h7f;
  localparam logic [2:0] CKS_TOP = 3'h7;
  localparam logic [1:0] EDGE_RISE_ONLY = 2'h1;

  typedef enum logic [2:0] {
    MD_INTERVAL = 3'h0,
    MD_EVENT = 3'h1,
    MD_EXTTRIG = 3'h2,
    MD_ONESHOT = 3'h3,
    MD_PWM = 3'h4,
    MD_FREE = 3'h5,
    MD_WIDTH = 3'h6,
    MD_BAD = 3'h7
  } tec_mode_t;

  typedef enum logic [2:0] {
    RUN_OFF = 3'b001,
    RUN_WAIT = 3'b010,
    RUN_GO = 3'b100
  } tec_run_t;
endpackage : tec_pkg

// File: rtl/tec_edge.sv
// Purpose: Pin synchroniser and selectable valid-edge detector
// Assumes: Pin is asynchronous to pclk
// Notes: Output pulse lasts one cycle
`timescale 1ns/1ns
`default_nettype none
module tec_edge
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and selection
  input wire logic pin_in,
  input wire logic [1:0] edge_sel,
  // Result
  output logic valid_edge
);
  import tec_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tec_edge_st_t;

  tec_edge_st_t st_reg;
  tec_edge_st_t st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Edge code: bit 0 rising, bit 1 falling
  assign valid_edge = (edge_sel[0] & st_reg.s2 & ~st_reg.s3) |
                      (edge_sel[1] & ~st_reg.s2 & st_reg.s3); // (R5) (R23)
endmodule : tec_edge
`default_nettype wire

// File: tb/tec_timer_ctrl_chk.sv
// Purpose: Assertions on the timer channel control ports
// Assumes: Zero wait APB slave
// Notes: Bound to tec_timer_ctrl
`timescale 1ns/1ns
`default_nettype none
module tec_chk
  import tec_pkg::*;
(
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Events
  input wire logic sync_tick_out,
  input wire logic match_one_irq,
  input wire logic trigger_start
);
  logic [7:0] ctl0_reg;
  logic [7:0] ctl0_next;
  logic wr0, wr1, rd_set;
  assign wr0 = psel && penable && pwrite && pstrb[0] && paddr == {IDX_CTL0, 2'b00};
  assign wr1 = psel && penable && pwrite && pstrb[0] && paddr == {IDX_CTL1, 2'b00};
  assign rd_set = psel && !penable && !pwrite;
  assign ctl0_next = wr0 ? (pwdata[7:0] & CTL0_MASK) : ctl0_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctl0_reg <= CTL0_RST;
    else
      ctl0_reg <= ctl0_next;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence trig_wr_s;
    wr1 && pwdata[BIT_SWTRIG] && ctl0_reg[BIT_RUN];
  endsequence
  irq_pulse_a: assert property (match_one_irq |=> !match_one_irq)
    else $error("match request longer than one cycle");
  trig_pulse_a: assert property (trigger_start |=> !trigger_start)
    else $error("trigger start longer than one cycle");
  trig_take_a: assert property (trig_wr_s ##0 (pwdata[2:1] == 2'b01) |-> ##[1:2] trigger_start)
    else $error("software trigger not taken");
  trig_skip_a: assert property (trig_wr_s ##0 (pwdata[2:1] != 2'b01) |=> !trigger_start [*2])
    else $error("software trigger not ignored");
  cnt_off_a: assert property (rd_set && paddr == {IDX_COUNT, 2'b00} && !ctl0_reg[BIT_RUN]
    |=> prdata == RD_ZERO)
    else $error("count read nonzero while stopped");
  ctl0_rd_a: assert property (rd_set && paddr == {IDX_CTL0, 2'b00} |=> prdata == {24'h0, $past(ctl0_reg)})
    else $error("control 0 readback wrong");
  tick_off_a: assert property (!ctl0_reg[BIT_RUN] |-> !sync_tick_out)
    else $error("tick while stopped");
  unmapped_a: assert property (psel && penable && paddr == {IDX_CAPCMP1 - 30'h1, 2'b00} |-> pslverr)
    else $error("unmapped access not refused");
endmodule : tec_chk

bind tec_timer_ctrl tec_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pslverr(pslverr), .sync_tick_out(sync_tick_out), .match_one_irq(match_one_irq),
  .trigger_start(trigger_start));
`default_nettype wire

// File: tb/tec_pins_model.sv
// Purpose: Far-side timer pins: event input pulses
// Assumes: Pins are asynchronous to pclk
// Notes: Spare pins stand still
`timescale 1ns/1ns
`default_nettype none
module tec_pins_model
(
  // Pins towards the channel
  output logic pin_a,
  output logic pin_b,
  output logic sub_clk
);
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    sub_clk = 1'b0;
  end
  // Levels held past the synchroniser delay
  task automatic pulses(input int cnt, input int hold);
    repeat (cnt)
    begin
      #hold pin_a = 1'b1;
      #hold pin_a = 1'b0;
    end
    #hold;
  endtask : pulses
endmodule : tec_pins_model
`default_nettype wire

// File: tb/test_timer_event_counter_control.sv
// Purpose: Self-checking bench for the timer channel control block
// Assumes: Zero wait APB slave, event pin from tec_pins_model
// Notes: Expected values come from the bench model
`timescale 1ns/1ns
`default_nettype none
module test_timer_event_counter_control;
  import tec_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [31:0] paddr, pwdata, prdata, q, seed;
  logic [3:0] pstrb;
  logic pin_a, pin_b, sub_clk, out_a, out_b, tick, irq, trig;
  int num_errors = 0;
  int check_count = 0;
  int trig_cnt = 0;
  int n, m, e, t;
  logic [29:0] rst_idx [4] = '{IDX_CTL0, IDX_CTL1, IDX_CAPCMP1, IDX_COUNT};
  tec_timer_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_a(pin_a), .timer_input_b(pin_b),
    .timer_output_a(out_a), .timer_output_b(out_b), .sub_clock_freq(sub_clk),
    .main_clock_stopped(1'b0), .sync_tick_in(1'b0), .sync_tick_out(tick),
    .match_one_irq(irq), .trigger_start(trig));
  tec_pins_model i_pins (.pin_a(pin_a), .pin_b(pin_b), .sub_clk(sub_clk));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (trig === 1'b1)
      trig_cnt <= trig_cnt + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input int lo, input int hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      num_errors++;
      $display("unexpected at %0t got %h expected %h", $time, got, lo);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [29:0] idx, input logic [31:0] d);
    // Request always starts just after a rising edge
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    #1;
  endtask : apb
  task automatic results();
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    #1000000;
    num_errors++;
    results();
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    {paddr, pwdata} = 64'h0;
    pstrb = 4'hf;
    seed = 32'h62825a09;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rst_idx[i])
    begin
      apb(1'b0, rst_idx[i], 32'h0);
      chk(q, 0, 0);
    end
    apb(1'b0, IDX_CAPCMP1 - 30'h1, 32'h0);
    chk(err_q, 1, 1);
    apb(1'b1, IDX_CTL1, 32'h45);
    apb(1'b0, IDX_CTL1, 32'h0);
    chk(q, 32'h05, 32'h05);
    seed = lfsr(seed);
    n = 2 + seed[4:0];
    apb(1'b1, IDX_OUTCTL, 32'h4);
    apb(1'b1, IDX_CAPCMP1, n);
    apb(1'b1, IDX_CTL0, 32'h80);
    m = 0;
    while (irq !== 1'b1 && m < 100)
    begin
      @(posedge pclk);
      #1;
      m++;
    end
    chk(m, n, n);
    @(posedge pclk);
    #1;
    chk(irq, 0, 0);
    chk(out_b, 1, 1);
    apb(1'b1, IDX_CTL0, 32'h0);
    chk(out_b, 0, 0);
    chk(out_a, 0, 0);
    apb(1'b0, IDX_COUNT, 32'h0);
    chk(q, 0, 0);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, IDX_CTL0, 32'h80 | k);
      repeat (256) @(posedge pclk);
      apb(1'b0, IDX_COUNT, 32'h0);
      chk(q, (256 >> k) - 1, (256 >> k) + 2);
      apb(1'b1, IDX_CTL0, k);
    end
    for (int c = 0; c < 5; c++)
    begin
      seed = lfsr(seed);
      m = (c == 4) ? 1 : c;
      e = (1 + seed[1:0]) * (m[0] + m[1]);
      apb(1'b1, IDX_EVTEDGE, m << 2);
      apb(1'b1, IDX_CTL1, (c == 4) ? 32'h25 : 32'h01);
      apb(1'b1, IDX_CTL0, 32'h80);
      i_pins.pulses(1 + seed[1:0], 300 + seed[8:2]);
      apb(1'b0, IDX_COUNT, 32'h0);
      chk(q, e, e);
      apb(1'b1, IDX_CTL0, 32'h0);
    end
    for (int md = 0; md < 7; md++)
    begin
      apb(1'b1, IDX_CTL1, md);
      apb(1'b1, IDX_CTL0, 32'h80);
      t = trig_cnt;
      apb(1'b1, IDX_CTL1, 32'h40 | md);
      repeat (2) @(posedge pclk);
      #1;
      chk(trig_cnt - t, (md == 2 || md == 3), (md == 2 || md == 3));
      apb(1'b1, IDX_CTL0, 32'h0);
    end
    results();
  end
endmodule : test_timer_event_counter_control
`default_nettype wire
